// file: wdtr_defines.svh
`ifndef WDTR_DEFINES_SVH
`define WDTR_DEFINES_SVH
// Function
// - Expiry while running issues a full device reset classed as watchdog reset.
// - Expiry while asleep wakes the device instead of resetting it.
// - An expiry clears the timeout flag unless a pin or brown-out reset comes in the same cycle.
// - Enable fuse at zero stops the watchdog for good; software cannot override.
// - Watchdog counts its own free-running tick, also during sleep.
// - Clear or sleep instruction zeroes the count and, if assigned, the postscaler.
// - Clearing zeroes the postscaler if assigned but leaves the prescaler assignment alone.
// - One shared prescaler; option bit 3 assigns it, bits 2:0 set ratio.
// - Six reset causes: power-on, pin run, pin sleep, watchdog, wake, brown-out.
// - Power-on, pin, watchdog and brown-out resets reload registers; wake does not.
// - Some registers are unset at power-on and kept through other resets.
// - Timeout and power-down flags follow a per-cause pattern software reads.

// ---------------------------------------------------------------
// Register map, word indices; byte address is four times the index
// ---------------------------------------------------------------
`define WDTR_ADDR_W        14
`define WDTR_IDX_OPTION    12'h081
`define WDTR_IDX_STATUS    12'h082
`define WDTR_IDX_IRQ_STAT  12'h083
`define WDTR_IDX_IRQ_MASK  12'h084
`define WDTR_IDX_SCRATCH   12'h085

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define WDTR_OPT_PSA       3
`define WDTR_OPT_PS_HI     2
`define WDTR_OPT_RESET     8'hFF
`define WDTR_SCRATCH_RESET 8'h00
`define WDTR_MASK_RESET    4'h0
`define WDTR_ST_TO         0
`define WDTR_ST_PD         1
`define WDTR_IRQ_WRST      0
`define WDTR_IRQ_WAKE      1
`define WDTR_IRQ_PIN       2
`define WDTR_IRQ_BOR       3
`define WDTR_RESP_OKAY     2'h0
`define WDTR_RESP_SLVERR   2'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WDTR_CLK_NS        8
`define WDTR_RC_TICK_NS    1000
`define WDTR_RC_DIV ((`WDTR_RC_TICK_NS + `WDTR_CLK_NS - 1) / `WDTR_CLK_NS)
`define WDTR_WDT_TICKS     1024
`define WDTR_FUSE_SETTLE   3'h6
`endif

// file: wdtr_pkg.sv
package wdtr_pkg;
   typedef enum logic [5:0] {
      CAUSE_POR       = 6'h01,
      CAUSE_PIN_RUN   = 6'h02,
      CAUSE_PIN_SLEEP = 6'h04,
      CAUSE_WDT_RST   = 6'h08,
      CAUSE_WDT_WAKE  = 6'h10,
      CAUSE_BOR       = 6'h20
   } wdtr_cause_type;
   typedef enum logic [1:0] {
      PWR_RUN   = 2'h1,
      PWR_SLEEP = 2'h2
   } wdtr_pwr_type;
endpackage

// file: wdtr_wdt_if.sv
`timescale 1ns/1ps
interface wdtr_wdt_if;
   logic       tick;
   logic       clear;
   logic       enable;
   logic       assign_wdt;
   logic [2:0] ratio;
   logic       expire;
   modport ctl  (output tick, clear, enable, assign_wdt, ratio,
                 input  expire);
   modport core (input  tick, clear, enable, assign_wdt, ratio,
                 output expire);
endinterface

// file: wdtr_sync.sv
`timescale 1ns/1ps
module wdtr_sync #(
   parameter int             W   = 1,
   parameter logic [W-1:0]   RST = '0
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import wdtr_pkg::*;
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;

   assign q = q_ff;

   // A bit moves only once the last two stages agree, filtering glitches.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_ff <= RST;
         s2_ff <= RST;
         s3_ff <= RST;
         q_ff  <= RST;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & q_ff);
      end
   end
endmodule

// file: wdtr_wdt.sv
`timescale 1ns/1ps
`include "wdtr_defines.svh"
module wdtr_wdt #(
   parameter int TICKS = `WDTR_WDT_TICKS
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   wdtr_wdt_if.core  w
);
   import wdtr_pkg::*;
   localparam int CW = $clog2(TICKS);

   logic [CW-1:0] cnt_ff;
   logic [7:0]    post_ff;
   logic          expire_ff;
   logic          base_end;

   function automatic logic [7:0] post_limit(input logic [2:0] r);
      post_limit = 8'((9'h001 << r) - 9'h001);
   endfunction

   assign w.expire = expire_ff;
   assign base_end = w.enable && w.tick && (cnt_ff == CW'(TICKS - 1));

   // ---------------------------------------------------------------
   // Base count and postscaler
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || w.clear) begin
         cnt_ff <= '0;
      end else if (w.enable && w.tick) begin
         cnt_ff <= base_end ? '0 : cnt_ff + 1'b1;
      end
   end

   // When the timer owns the prescaler this count stays idle and untouched.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         post_ff <= 8'h00;
      end else if (w.clear && w.assign_wdt) begin
         post_ff <= 8'h00;
      end else if (base_end && w.assign_wdt) begin
         post_ff <= (post_ff == post_limit(w.ratio)) ? 8'h00
                                                      : post_ff + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         expire_ff <= 1'b0;
      end else begin
         expire_ff <= base_end && !w.clear &&
                      (!w.assign_wdt || post_ff == post_limit(w.ratio));
      end
   end

   fuse_gate_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !w.enable |=> !w.expire)
      else $error("Watchdog expired while disabled.");

   clear_zero_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      w.clear && w.assign_wdt |=> cnt_ff == '0 && post_ff == 8'h00
                                  && !w.expire)
      else $error("Clear left the watchdog count running.");
endmodule

// file: wdtr_top.sv
`timescale 1ns/1ps
`include "wdtr_defines.svh"
module wdtr_top #(
   parameter int RC_DIV    = `WDTR_RC_DIV,
   parameter int WDT_TICKS = `WDTR_WDT_TICKS
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [`WDTR_ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [`WDTR_ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   input  wire logic                   master_clear_n,
   input  wire logic                   brownout_n,
   input  wire logic                   watchdog_enable_fuse,
   input  wire logic                   watchdog_clear_instr,
   input  wire logic                   sleep_instr,
   output logic                        dev_reset,
   output logic                        wake,
   output logic                        irq,
   output wdtr_pkg::wdtr_cause_type    reset_cause
);
   import wdtr_pkg::*;
   localparam int IW = `WDTR_ADDR_W - 2;
   localparam int DW = (RC_DIV > 1) ? $clog2(RC_DIV) : 1;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic           awready_ff;
   logic           aw_got_ff;
   logic [IW-1:0]  aw_idx_ff;
   logic           wready_ff;
   logic           w_got_ff;
   logic [31:0]    wdata_ff;
   logic [3:0]     wstrb_ff;
   logic           bvalid_ff;
   logic [1:0]     bresp_ff;
   logic           arready_ff;
   logic           rvalid_ff;
   logic [31:0]    rdata_ff;
   logic [1:0]     rresp_ff;
   logic [7:0]     option_ff;
   logic [7:0]     scratch_ff;
   logic [3:0]     irq_stat_ff;
   logic [3:0]     irq_mask_ff;
   logic           to_ff;
   logic           pd_ff;
   wdtr_cause_type cause_ff;
   wdtr_pwr_type   pwr_ff;
   logic           dev_reset_ff;
   logic           wake_ff;
   logic           irq_ff;
   logic           fuse_en_ff;
   logic [2:0]     settle_ff;
   logic [DW-1:0]  rc_div_ff;
   logic           tick_ff;
   logic [2:0]     pin_prev_ff;
   logic [2:0]     pin_q;
   logic           wr_do;
   logic           opt_wr;
   logic           master_clear_pin_evt;
   logic           bor_evt;
   logic           wdt_evt;
   logic           rst_evt;
   logic           asleep;
   logic [3:0]     irq_ev;
   logic [31:0]    rd_word;

   wdtr_wdt_if wdt_bus ();

   function automatic logic idx_ok(input logic [IW-1:0] idx);
      idx_ok = idx inside {`WDTR_IDX_OPTION, `WDTR_IDX_STATUS,
                           `WDTR_IDX_IRQ_STAT, `WDTR_IDX_IRQ_MASK,
                           `WDTR_IDX_SCRATCH};
   endfunction

   function automatic logic lane0_wr(input logic [IW-1:0] idx,
                                     input logic [IW-1:0] hit,
                                     input logic          go,
                                     input logic [3:0]    strb);
      lane0_wr = go && idx == hit && strb[0];
   endfunction

   assign awready     = awready_ff;
   assign wready      = wready_ff;
   assign bvalid      = bvalid_ff;
   assign bresp       = bresp_ff;
   assign arready     = arready_ff;
   assign rvalid      = rvalid_ff;
   assign rdata       = rdata_ff;
   assign rresp       = rresp_ff;
   assign dev_reset   = dev_reset_ff;
   assign wake        = wake_ff;
   assign irq         = irq_ff;
   assign reset_cause = cause_ff;

   // ---------------------------------------------------------------
   // Pins and events
   // ---------------------------------------------------------------
   wdtr_sync #(.W(3), .RST(3'h3)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({watchdog_enable_fuse, brownout_n, master_clear_n}),
      .q       (pin_q)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev_ff <= 3'h3;
      end else begin
         pin_prev_ff <= pin_q;
      end
   end

   assign wr_do    = aw_got_ff && w_got_ff && !bvalid_ff;
   assign opt_wr   = lane0_wr(aw_idx_ff, `WDTR_IDX_OPTION, wr_do, wstrb_ff);
   assign master_clear_pin_evt = pin_prev_ff[0] && !pin_q[0];
   assign bor_evt  = pin_prev_ff[1] && !pin_q[1];
   assign wdt_evt  = wdt_bus.expire;
   assign asleep   = (pwr_ff == PWR_SLEEP);
   assign rst_evt  = master_clear_pin_evt || bor_evt || (wdt_evt && !asleep);
   assign irq_ev   = {bor_evt, master_clear_pin_evt,
                      wdt_evt && asleep && !master_clear_pin_evt && !bor_evt,
                      wdt_evt && !asleep};

   // The fuse is sampled only until the synchroniser has settled, so a
   // later change on the pin or any register write cannot revive it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         settle_ff  <= 3'h0;
         fuse_en_ff <= 1'b0;
      end else if (settle_ff != `WDTR_FUSE_SETTLE) begin
         settle_ff  <= settle_ff + 3'h1;
         fuse_en_ff <= pin_q[2];
      end
   end

   // Stands in for the private RC oscillator; it ignores sleep entirely.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rc_div_ff <= '0;
         tick_ff   <= 1'b0;
      end else begin
         tick_ff   <= (rc_div_ff == DW'(RC_DIV - 1));
         rc_div_ff <= (rc_div_ff == DW'(RC_DIV - 1)) ? '0
                                                      : rc_div_ff + 1'b1;
      end
   end

   assign wdt_bus.tick       = tick_ff;
   assign wdt_bus.clear      = watchdog_clear_instr || sleep_instr
                               || rst_evt;
   assign wdt_bus.enable     = fuse_en_ff;
   assign wdt_bus.assign_wdt = option_ff[`WDTR_OPT_PSA];
   assign wdt_bus.ratio      = option_ff[`WDTR_OPT_PS_HI:0];

   wdtr_wdt #(.TICKS(WDT_TICKS)) u_wdt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .w       (wdt_bus.core)
   );

   // ---------------------------------------------------------------
   // Power state, reset and wake outputs
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_ff <= PWR_RUN;
      end else begin
         unique case (pwr_ff)
            PWR_RUN: begin
               if (sleep_instr && !rst_evt) begin
                  pwr_ff <= PWR_SLEEP;
               end
            end
            PWR_SLEEP: begin
               if (wdt_evt || master_clear_pin_evt || bor_evt) begin
                  pwr_ff <= PWR_RUN;
               end
            end
            default: pwr_ff <= PWR_RUN;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dev_reset_ff <= 1'b0;
         wake_ff      <= 1'b0;
      end else begin
         dev_reset_ff <= rst_evt || !pin_q[0] || !pin_q[1];
         wake_ff      <= irq_ev[`WDTR_IRQ_WAKE];
      end
   end

   // ---------------------------------------------------------------
   // Cause and status flags
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         to_ff    <= 1'b1;
         pd_ff    <= 1'b1;
         cause_ff <= CAUSE_POR;
      end else if (bor_evt) begin
         to_ff    <= 1'b1;
         pd_ff    <= 1'b1;
         cause_ff <= CAUSE_BOR;
      end else if (master_clear_pin_evt) begin
         cause_ff <= asleep ? CAUSE_PIN_SLEEP : CAUSE_PIN_RUN;
         if (asleep) begin
            to_ff <= 1'b1;
            pd_ff <= 1'b0;
         end
      end else if (wdt_evt) begin
         to_ff    <= 1'b0;
         cause_ff <= asleep ? CAUSE_WDT_WAKE : CAUSE_WDT_RST;
         if (asleep) begin
            pd_ff <= 1'b0;
         end
      end else if (watchdog_clear_instr) begin
         to_ff <= 1'b1;
         pd_ff <= 1'b1;
      end else if (sleep_instr) begin
         to_ff <= 1'b1;
         pd_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || rst_evt) begin
         option_ff <= `WDTR_OPT_RESET;
      end else if (opt_wr) begin
         option_ff <= wdata_ff[7:0];
      end
   end

   // Only power-on touches this word; every other reset leaves it alone.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scratch_ff <= `WDTR_SCRATCH_RESET;
      end else if (lane0_wr(aw_idx_ff, `WDTR_IDX_SCRATCH, wr_do,
                            wstrb_ff)) begin
         scratch_ff <= wdata_ff[7:0];
      end
   end

   // A new event beats a write-one-to-clear of the same bit.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_ff <= 4'h0;
      end else if (lane0_wr(aw_idx_ff, `WDTR_IDX_IRQ_STAT, wr_do,
                            wstrb_ff)) begin
         irq_stat_ff <= (irq_stat_ff & ~wdata_ff[3:0]) | irq_ev;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_ev;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_ff <= `WDTR_MASK_RESET;
         irq_ff      <= 1'b0;
      end else begin
         if (lane0_wr(aw_idx_ff, `WDTR_IDX_IRQ_MASK, wr_do, wstrb_ff)) begin
            irq_mask_ff <= wdata_ff[3:0];
         end
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         aw_got_ff  <= 1'b0;
         aw_idx_ff  <= '0;
      end else begin
         if (awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_got_ff  <= 1'b1;
            aw_idx_ff  <= awaddr[`WDTR_ADDR_W-1:2];
         end else if (wr_do) begin
            aw_got_ff <= 1'b0;
         end
         if (bvalid_ff && bready) begin
            awready_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_ff <= 1'b1;
         w_got_ff  <= 1'b0;
         wdata_ff  <= 32'h0;
         wstrb_ff  <= 4'h0;
      end else begin
         if (wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_got_ff  <= 1'b1;
            wdata_ff  <= wdata;
            wstrb_ff  <= wstrb;
         end else if (wr_do) begin
            w_got_ff <= 1'b0;
         end
         if (bvalid_ff && bready) begin
            wready_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `WDTR_RESP_OKAY;
      end else if (wr_do) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= idx_ok(aw_idx_ff) ? `WDTR_RESP_OKAY
                                        : `WDTR_RESP_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_comb begin
      rd_word = 32'h0;
      unique case (araddr[`WDTR_ADDR_W-1:2])
         `WDTR_IDX_OPTION:   rd_word = {24'h0, option_ff};
         `WDTR_IDX_STATUS:   rd_word = {18'h0, cause_ff, 6'h00,
                                        pd_ff, to_ff};
         `WDTR_IDX_IRQ_STAT: rd_word = {28'h0, irq_stat_ff};
         `WDTR_IDX_IRQ_MASK: rd_word = {28'h0, irq_mask_ff};
         `WDTR_IDX_SCRATCH:  rd_word = {24'h0, scratch_ff};
         default:            rd_word = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0;
         rresp_ff   <= `WDTR_RESP_OKAY;
      end else if (arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= rd_word;
         rresp_ff   <= idx_ok(araddr[`WDTR_ADDR_W-1:2]) ? `WDTR_RESP_OKAY
                                                         : `WDTR_RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   wdt_reset_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wdt_evt && !asleep && !master_clear_pin_evt && !bor_evt
      |=> dev_reset_ff && cause_ff == CAUSE_WDT_RST && !wake_ff)
      else $error("Running expiry did not give a watchdog reset.");

   wdt_wake_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wdt_evt && asleep && !master_clear_pin_evt && !bor_evt
      |=> wake_ff && pwr_ff == PWR_RUN && cause_ff == CAUSE_WDT_WAKE
          ##1 !wake_ff)
      else $error("Sleeping expiry did not wake for one cycle.");

   to_clear_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wdt_evt && !master_clear_pin_evt && !bor_evt |=> !to_ff)
      else $error("Expiry left the timeout flag set.");

   rc_free_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> rc_div_ff != $past(rc_div_ff))
      else $error("Watchdog tick divider stalled.");

   opt_keep_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      watchdog_clear_instr && !rst_evt && !opt_wr
      |=> option_ff == $past(option_ff))
      else $error("Clear changed the prescaler assignment.");

   cause_hot_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $onehot(cause_ff))
      else $error("Reset cause is not a single source.");

   opt_reset_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rst_evt |=> option_ff == `WDTR_OPT_RESET && dev_reset_ff)
      else $error("Device reset did not reload the option register.");

   sleep_flag_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      sleep_instr && !rst_evt && !wdt_evt
      |=> to_ff && !pd_ff && pwr_ff == PWR_SLEEP)
      else $error("Sleep did not set timeout and clear power-down.");
endmodule

// file: wdtr_core_model.sv
`timescale 1ns/1ps
module wdtr_core_model (
   input  wire logic aclk,
   input  wire logic do_clear,
   input  wire logic do_sleep,
   output logic      watchdog_clear_instr,
   output logic      sleep_instr
);
   // A core issues each instruction as a single-cycle strobe on aclk.
   initial begin
      watchdog_clear_instr = 1'b0;
      sleep_instr = 1'b0;
   end
   always @(posedge aclk) begin
      watchdog_clear_instr <= do_clear;
      sleep_instr          <= do_sleep;
   end
endmodule

// file: test_watchdog_and_reset_cause.sv
`timescale 1ns/1ps
`include "wdtr_defines.svh"
module test_watchdog_and_reset_cause;
   import wdtr_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic fuse, clr, slp, do_clr, do_slp, awready, wready, bvalid;
   logic arready, rvalid, dev_reset, wake, irq, master_clear_pin_n, bor_n;
   logic [13:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   wdtr_cause_type cause;
   int error_cnt, compares, n0, n1, seen;
   wdtr_top #(.RC_DIV(2), .WDT_TICKS(4)) wdtr_top_i (.aclk(aclk),
      .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .master_clear_n(master_clear_pin_n), .brownout_n(bor_n),
      .watchdog_enable_fuse(fuse), .watchdog_clear_instr(clr),
      .sleep_instr(slp), .dev_reset(dev_reset), .wake(wake), .irq(irq),
      .reset_cause(cause));
   wdtr_core_model wdtr_core_model_i (.aclk(aclk), .do_clear(do_clr),
      .do_sleep(do_slp), .watchdog_clear_instr(clr), .sleep_instr(slp));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic results;
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tmo;
      error_cnt++;
      $display("[ERR] %0t wait ran out", $time);
      results();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] v);
      int n;
      n = 0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, v};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!(bvalid && !awvalid && !wvalid) && n < 50);
      r = bresp;
      if (n >= 50) tmo();
   endtask
   task automatic rd(input logic [11:0] idx);
      int n;
      n = 0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!(rvalid && !arvalid) && n < 50);
      d = rdata;
      r = rresp;
      if (n >= 50) tmo();
   endtask
   task automatic rchk(input logic [11:0] idx, input logic [31:0] m,
                       input logic [31:0] exp);
      rd(idx);
      chk(d & m, exp);
   endtask
   task automatic strobe(input bit sleep);
      if (sleep) do_slp <= 1'b1;
      else do_clr <= 1'b1;
      @(posedge aclk);
      do_slp <= 1'b0;
      do_clr <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic wait_ev(output int n);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!(dev_reset || wake) && n < 200);
      if (n >= 200) tmo();
   endtask
   task automatic run_reset(input logic f);
      aresetn <= 1'b0;
      fuse <= f;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (10) @(posedge aclk);
   endtask
   task automatic pin_drop(input bit bor);
      if (bor) bor_n <= 1'b0;
      else master_clear_pin_n <= 1'b0;
      repeat (8) @(posedge aclk);
   endtask
   task automatic pin_rise;
      {master_clear_pin_n, bor_n} <= 2'b11;
      repeat (8) @(posedge aclk);
   endtask
   task automatic t_boot;
      run_reset(1'b1);
      rchk(`WDTR_IDX_OPTION, 32'hFF, 32'hFF);
      rchk(`WDTR_IDX_STATUS, 32'h3F03, 32'h0103);
      chk(cause, CAUSE_POR);
      rd(12'h0FF);
      chk(r, `WDTR_RESP_SLVERR);
   endtask
   task automatic t_wdt_reset;
      wr(`WDTR_IDX_SCRATCH, 8'h5A);
      wr(`WDTR_IDX_IRQ_MASK, 8'h03);
      wr(`WDTR_IDX_OPTION, 8'h00);
      strobe(0);
      wait_ev(n0);
      chk(dev_reset, 1'b1);
      chk(cause, CAUSE_WDT_RST);
      @(posedge aclk);
      rchk(`WDTR_IDX_STATUS, 32'h3F03, 32'h0802);
      rchk(`WDTR_IDX_OPTION, 32'hFF, 32'hFF);
      rchk(`WDTR_IDX_SCRATCH, 32'hFF, 32'h5A);
      chk(irq, 1'b1);
      wr(`WDTR_IDX_IRQ_STAT, 8'h01);
      @(posedge aclk);
      chk(irq, 1'b0);
   endtask
   task automatic t_postscale;
      wr(`WDTR_IDX_OPTION, 8'h09);
      strobe(0);
      rchk(`WDTR_IDX_OPTION, 32'hFF, 32'h09);
      wait_ev(n1);
      chk(n1 > n0 + 4, 1'b1);
   endtask
   task automatic t_clear;
      wr(`WDTR_IDX_OPTION, 8'h00);
      seen = 0;
      repeat (10) begin
         strobe(0);
         if (dev_reset) seen++;
      end
      chk(seen, 0);
      rchk(`WDTR_IDX_STATUS, 32'h03, 32'h03);
   endtask
   task automatic t_sleep_wake;
      wr(`WDTR_IDX_OPTION, 8'h09);
      strobe(1);
      rchk(`WDTR_IDX_STATUS, 32'h03, 32'h01);
      wait_ev(n0);
      chk({wake, dev_reset}, 2'b10);
      chk(cause, CAUSE_WDT_WAKE);
      @(posedge aclk);
      rchk(`WDTR_IDX_STATUS, 32'h3F03, 32'h1000);
      rchk(`WDTR_IDX_OPTION, 32'hFF, 32'h09);
   endtask
   task automatic t_pins;
      pin_drop(0);
      chk(dev_reset, 1'b1);
      chk(cause, CAUSE_PIN_RUN);
      pin_rise();
      rchk(`WDTR_IDX_STATUS, 32'h3F03, 32'h0200);
      rchk(`WDTR_IDX_OPTION, 32'hFF, 32'hFF);
      strobe(1);
      pin_drop(0);
      chk(cause, CAUSE_PIN_SLEEP);
      pin_rise();
      rchk(`WDTR_IDX_STATUS, 32'h3F03, 32'h0401);
      pin_drop(1);
      chk(cause, CAUSE_BOR);
      pin_rise();
      rchk(`WDTR_IDX_STATUS, 32'h3F03, 32'h2003);
      rchk(`WDTR_IDX_IRQ_STAT, 32'h0F, 32'h0F);
   endtask
   task automatic t_fuse_off;
      run_reset(1'b0);
      wr(`WDTR_IDX_OPTION, 8'h00);
      wr(12'h0FF, 8'h00);
      chk(r, `WDTR_RESP_SLVERR);
      seen = 0;
      repeat (150) begin
         @(posedge aclk);
         if (dev_reset || wake) seen++;
      end
      chk(seen, 0);
   endtask
   initial begin
      {awvalid, wvalid, arvalid, do_clr, do_slp} = '0;
      {bready, rready, master_clear_pin_n, bor_n} = '1;
      {awaddr, araddr, wdata, wstrb, error_cnt, compares} = '0;
      t_boot();
      t_wdt_reset();
      t_postscale();
      t_clear();
      t_sleep_wake();
      t_pins();
      t_fuse_off();
      results();
   end
endmodule
